// ==== rtl/rlfs_top.sv ====
/*
  Receive lane fault status: lane map, demux lock, FCS counts, truncation,
  fault levels, BIP8 errors and high error rate, with an interrupt.
  Assumes all inputs are produced by receive logic on clk_sys.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rlfs_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Lane alignment inputs
  input wire logic [rlfs_pkg::NUM_LANES*rlfs_pkg::LANE_IDX_W-1:0] lane_map_in,
  input wire logic [rlfs_pkg::NUM_LANES-1:0] lane_sync_in,
  input wire logic [rlfs_pkg::NUM_LANES-1:0] lane_demux_in,
  input wire logic align_ok,
  // Packet inputs
  input wire rlfs_pkg::rlfs_fcs_t fcs_ends [4],
  input wire logic pkt_start,
  input wire logic [7:0] pkt_bytes,
  // Marker inputs
  input wire rlfs_pkg::rlfs_bip_t bip_in,
  // Fault causes
  input wire logic test_pattern_on,
  input wire logic ber_excess_in,
  input wire logic partner_fault_in,
  // Register port
  input wire rlfs_pkg::rlfs_bus_t bus,
  output logic [31:0] rdata,
  // Status outputs
  output logic [rlfs_pkg::NUM_LANES*rlfs_pkg::LANE_IDX_W-1:0] lane_index,
  output logic [rlfs_pkg::LANE_IDX_W-1:0] pcs_lane19_physical_index,
  output logic [rlfs_pkg::NUM_LANES-1:0] lane_sync_vector,
  output logic [rlfs_pkg::NUM_LANES-1:0] lane_marker_found_vector,
  output logic [rlfs_pkg::CNT_W-1:0] bad_checksum_count,
  output logic [rlfs_pkg::CNT_W-1:0] inverted_checksum_count,
  output logic truncated_pulse,
  output logic cut_packet,
  output logic internal_fault,
  output logic received_fault,
  output logic [rlfs_pkg::NUM_LANES-1:0] bip_error,
  output logic error_rate_excess_flag,
  output logic irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [rlfs_pkg::NUM_LANES*rlfs_pkg::LANE_IDX_W-1:0] map;
    logic [rlfs_pkg::LANE_IDX_W-1:0] map19;
    logic [rlfs_pkg::NUM_LANES-1:0] sync;
    logic [rlfs_pkg::NUM_LANES-1:0] demux;
    logic in_pkt;
    logic cut;
    logic [rlfs_pkg::LEN_W-1:0] len;
    logic trunc;
    logic int_lf;
    logic rx_lf;
    logic hi_ber;
    logic [rlfs_pkg::LEN_W-1:0] max_len;
    logic [rlfs_pkg::IRQ_W-1:0] status;
    logic [rlfs_pkg::IRQ_W-1:0] enable;
    logic [31:0] rdata;
    logic irq;
  } rlfs_state_t;

  rlfs_state_t st;
  rlfs_state_t next_st;
  rlfs_pkg::rlfs_fcs_cnt_t fcs_cnt;
  logic [rlfs_pkg::NUM_LANES-1:0] bip_err;
  logic [rlfs_pkg::IRQ_W-1:0] events;
  logic [rlfs_pkg::LEN_W:0] len_sum;

  // ---------------------------------------------------------------
  // Sub blocks
  // ---------------------------------------------------------------
  rlfs_fcs_classify u_fcs (
    .clk_sys(clk_sys),
    .srst(srst),
    .ends(fcs_ends),
    .counts(fcs_cnt)
  );

  rlfs_bip_check u_bip (
    .clk_sys(clk_sys),
    .srst(srst),
    .bip(bip_in),
    .err(bip_err)
  );

  function automatic logic hit(input logic [rlfs_pkg::ADDR_W-1:0] a,
                               input logic [rlfs_pkg::ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  assign len_sum = {1'b0, st.len} + {8'h00, pkt_bytes};

  always_comb begin
    events = '0;
    events[rlfs_pkg::IRQ_BAD_FCS] = |fcs_cnt.bad;
    events[rlfs_pkg::IRQ_STOMPED] = |fcs_cnt.stomped;
    events[rlfs_pkg::IRQ_TRUNC] = st.trunc;
    events[rlfs_pkg::IRQ_BIP] = |bip_err;
    events[rlfs_pkg::IRQ_INT_LF] = st.int_lf;
    events[rlfs_pkg::IRQ_HI_BER] = st.hi_ber;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.map = lane_map_in;
    next_st.map19 = lane_map_in[19*rlfs_pkg::LANE_IDX_W +:
                                rlfs_pkg::LANE_IDX_W];
    next_st.sync = lane_sync_in;
    next_st.demux = lane_demux_in & lane_sync_in;
    next_st.trunc = 1'b0;
    if (pkt_start) begin
      next_st.in_pkt = 1'b1;
      next_st.cut = 1'b0;
      next_st.len = {7'h00, pkt_bytes};
    end else if (st.in_pkt && !st.cut) begin
      next_st.len = len_sum[rlfs_pkg::LEN_W] ? '1 :
                    len_sum[rlfs_pkg::LEN_W-1:0];
    end
    if (st.in_pkt && !st.cut &&
        (len_sum > {1'b0, st.max_len}) && !pkt_start) begin
      next_st.cut = 1'b1;
      next_st.trunc = 1'b1;
    end
    next_st.int_lf = test_pattern_on || !align_ok || ber_excess_in;
    next_st.rx_lf = partner_fault_in;
    next_st.hi_ber = ber_excess_in;
    // Register writes and interrupt status; a new event beats a clear.
    if (bus.wr && hit(bus.addr, rlfs_pkg::OFS_IRQ_ENABLE)) begin
      next_st.enable = bus.wdata[rlfs_pkg::IRQ_W-1:0];
    end
    if (bus.wr && hit(bus.addr, rlfs_pkg::OFS_MAX_LEN)) begin
      next_st.max_len = bus.wdata[rlfs_pkg::LEN_W-1:0];
    end
    if (bus.wr && hit(bus.addr, rlfs_pkg::OFS_IRQ_CLEAR)) begin
      next_st.status = st.status & ~bus.wdata[rlfs_pkg::IRQ_W-1:0];
    end
    next_st.status = next_st.status | events;
    next_st.irq = |(next_st.status & next_st.enable);
    next_st.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        rlfs_pkg::OFS_IRQ_STATUS: begin
          next_st.rdata[rlfs_pkg::IRQ_W-1:0] = st.status;
        end
        rlfs_pkg::OFS_IRQ_ENABLE: begin
          next_st.rdata[rlfs_pkg::IRQ_W-1:0] = st.enable;
        end
        rlfs_pkg::OFS_MAX_LEN: begin
          next_st.rdata[rlfs_pkg::LEN_W-1:0] = st.max_len;
        end
        rlfs_pkg::OFS_LEVELS: begin
          next_st.rdata[2:0] = {st.hi_ber, st.rx_lf, st.int_lf};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (srst) begin
      next_st = '0;
      next_st.map = '0;
      next_st.map19 = rlfs_pkg::LANE_IDX_RST;
      next_st.len = rlfs_pkg::LEN_RST;
      next_st.max_len = rlfs_pkg::MAX_LEN_RST;
      next_st.status = rlfs_pkg::IRQ_RST;
      next_st.enable = rlfs_pkg::IRQ_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign lane_index = st.map;
  assign pcs_lane19_physical_index = st.map19;
  assign lane_sync_vector = st.sync;
  assign lane_marker_found_vector = st.demux;
  assign bad_checksum_count = fcs_cnt.bad;
  assign inverted_checksum_count = fcs_cnt.stomped;
  assign truncated_pulse = st.trunc;
  assign cut_packet = st.cut;
  assign internal_fault = st.int_lf;
  assign received_fault = st.rx_lf;
  assign bip_error = bip_err;
  assign error_rate_excess_flag = st.hi_ber;
  assign irq = st.irq;
  assign rdata = st.rdata;

endmodule
`default_nettype wire

// ==== rtl/rlfs_pkg.sv ====
/*
  Shared types and constants for the receive lane fault status block.
  Assumes a single receive clock domain and a synchronous reset.
*/
package rlfs_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_LANES = 20;
  localparam int LANE_IDX_W = 5;
  localparam int CNT_W = 4;
  localparam int LEN_W = 15;
  localparam int FCS_W = 32;
  localparam int BIP_W = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [LANE_IDX_W-1:0] LANE_IDX_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [LEN_W-1:0] LEN_RST = 15'h0000;

  // ---------------------------------------------------------------
  // Register offsets and interrupt layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_MAX_LEN = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_LEVELS = 4'h4;
  localparam int IRQ_W = 6;
  localparam int IRQ_BAD_FCS = 0;
  localparam int IRQ_STOMPED = 1;
  localparam int IRQ_TRUNC = 2;
  localparam int IRQ_BIP = 3;
  localparam int IRQ_INT_LF = 4;
  localparam int IRQ_HI_BER = 5;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
  localparam logic [LEN_W-1:0] MAX_LEN_RST = 15'h25ee;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pkt_end;
    logic [FCS_W-1:0] fcs_rx;
    logic [FCS_W-1:0] fcs_calc;
  } rlfs_fcs_t;

  typedef struct packed {
    logic [CNT_W-1:0] bad;
    logic [CNT_W-1:0] stomped;
  } rlfs_fcs_cnt_t;

  typedef struct packed {
    logic [NUM_LANES-1:0] marker_valid;
    logic [NUM_LANES*BIP_W-1:0] bip_rx;
    logic [NUM_LANES*BIP_W-1:0] bip_calc;
  } rlfs_bip_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rlfs_bus_t;

endpackage

// ==== rtl/rlfs_fcs_classify.sv ====
/*
  Classifies up to four packet endings per cycle as good, bad or stomped.
  Assumes inputs come from logic on the same receive clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rlfs_fcs_classify (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Packet endings
  input wire rlfs_pkg::rlfs_fcs_t ends [4],
  // Counts
  output rlfs_pkg::rlfs_fcs_cnt_t counts
);

  typedef struct packed {
    rlfs_pkg::rlfs_fcs_cnt_t cnt;
  } rlfs_fc_state_t;

  rlfs_fc_state_t st;
  rlfs_fc_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.cnt.bad = rlfs_pkg::CNT_RST;
    next_st.cnt.stomped = rlfs_pkg::CNT_RST;
    for (int i = 0; i < 4; i++) begin
      if (ends[i].pkt_end) begin
        if (ends[i].fcs_rx == ~ends[i].fcs_calc) begin
          next_st.cnt.stomped = next_st.cnt.stomped + 4'h1;
        end else if (ends[i].fcs_rx != ends[i].fcs_calc) begin
          next_st.cnt.bad = next_st.cnt.bad + 4'h1;
        end
      end
    end
    if (srst) begin
      next_st.cnt.bad = rlfs_pkg::CNT_RST;
      next_st.cnt.stomped = rlfs_pkg::CNT_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign counts = st.cnt;

endmodule
`default_nettype wire

// ==== rtl/rlfs_bip_check.sv ====
/*
  Checks the BIP8 byte of each PCS lane marker and pulses per lane errors.
  Assumes inputs come from logic on the same receive clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rlfs_bip_check (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Marker data
  input wire rlfs_pkg::rlfs_bip_t bip,
  // Error pulses
  output logic [rlfs_pkg::NUM_LANES-1:0] err
);

  typedef struct packed {
    logic [rlfs_pkg::NUM_LANES-1:0] err;
  } rlfs_bc_state_t;

  rlfs_bc_state_t st;
  rlfs_bc_state_t next_st;
  logic [rlfs_pkg::NUM_LANES-1:0] mism;

  genvar g;
  generate
    for (g = 0; g < rlfs_pkg::NUM_LANES; g++) begin : g_lane
      assign mism[g] = bip.marker_valid[g] &&
        (bip.bip_rx[g*rlfs_pkg::BIP_W +: rlfs_pkg::BIP_W] !=
         bip.bip_calc[g*rlfs_pkg::BIP_W +: rlfs_pkg::BIP_W]);
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.err = mism;
    if (srst) begin
      next_st.err = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign err = st.err;

endmodule
`default_nettype wire

// ==== bench/rlfs_chk.sv ====
/*
  Checker of the receive lane fault status block.
  Assumes it is bound to rlfs_top and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module rlfs_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Causes
  input wire logic [99:0] lane_map_in,
  input wire logic [19:0] lane_sync_in,
  input wire logic [19:0] lane_demux_in,
  input wire logic align_ok,
  input wire logic test_pattern_on,
  input wire logic ber_excess_in,
  input wire logic partner_fault_in,
  input wire rlfs_pkg::rlfs_bip_t bip_in,
  // Status
  input wire logic [99:0] lane_index,
  input wire logic [4:0] pcs_lane19_physical_index,
  input wire logic [19:0] lane_marker_found_vector,
  input wire logic [3:0] bad_checksum_count,
  input wire logic [3:0] inverted_checksum_count,
  input wire logic truncated_pulse,
  input wire logic cut_packet,
  input wire logic internal_fault,
  input wire logic received_fault,
  input wire logic [19:0] bip_error,
  input wire logic error_rate_excess_flag,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  map_copy_a:
  assert property (!$past(srst) |-> lane_index == $past(lane_map_in))
    else $error("lane index not copied");
  lane_last_a:
  assert property (pcs_lane19_physical_index == lane_index[99:95])
    else $error("lane 19 index wrong");
  found_gate_a:
  assert property (!$past(srst) |-> lane_marker_found_vector ==
    ($past(lane_demux_in) & $past(lane_sync_in)))
    else $error("found vector wrong");
  count_sum_a:
  assert property ({1'b0, bad_checksum_count} +
    {1'b0, inverted_checksum_count} <= 5'h4)
    else $error("more ends counted than slots");
  trunc_cut_a:
  assert property (truncated_pulse |-> cut_packet)
    else $error("truncation without cut");
  int_fault_a:
  assert property (!$past(srst) |-> internal_fault == ($past(test_pattern_on)
    | !$past(align_ok) | $past(ber_excess_in)))
    else $error("internal fault wrong");
  rx_fault_a:
  assert property (!$past(srst) |-> received_fault == $past(partner_fault_in))
    else $error("received fault wrong");
  bip_gate_a:
  assert property (!$past(srst) |->
    (bip_error & ~$past(bip_in.marker_valid)) == 20'h0)
    else $error("bip error without marker");
  ber_flag_a:
  assert property (!$past(srst) |->
    error_rate_excess_flag == $past(ber_excess_in))
    else $error("error rate flag wrong");
  reset_quiet_a:
  assert property (disable iff (1'b0) srst |=> (bad_checksum_count == 4'h0
    && inverted_checksum_count == 4'h0 && !truncated_pulse && !irq
    && bip_error == 20'h0 && !internal_fault && !error_rate_excess_flag))
    else $error("outputs active in reset");
  cover property (truncated_pulse);
  cover property (inverted_checksum_count != 4'h0);
  cover property (irq);
endmodule
bind rlfs_top rlfs_chk rlfs_chk_inst (.*);
`default_nettype wire

// ==== bench/rlfs_partner.sv ====
/*
  Remote link partner: sends packet endings and lane markers.
  Assumes its controls change just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rlfs_partner (
  // Controls
  input wire logic [7:0] kind,
  input wire logic mark,
  input wire logic [19:0] bip_bad,
  input wire logic [31:0] seed,
  // Link side
  output rlfs_pkg::rlfs_fcs_t ends [4],
  output rlfs_pkg::rlfs_bip_t bip
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ends[i].pkt_end = kind[2*i+:2] != 2'h0;
      ends[i].fcs_calc = seed + i;
      case (kind[2*i+:2])
        2'h2: ends[i].fcs_rx = seed + i + 32'h1;
        2'h3: ends[i].fcs_rx = ~(seed + i);
        default: ends[i].fcs_rx = seed + i;
      endcase
    end
    bip.marker_valid = {20{mark}};
    bip.bip_calc = {20{seed[7:0]}};
    for (int l = 0; l < 20; l++)
      bip.bip_rx[8*l+:8] = seed[7:0] ^ {8{bip_bad[l]}};
  end
endmodule
`default_nettype wire

// ==== bench/rlfs_top_tb_top.sv ====
/*
  Testbench of the receive lane fault status block.
  Assumes the partner model supplies endings and markers.
*/
`timescale 1ns/1ps
`default_nettype none
module rlfs_top_tb_top;
  typedef struct {int unsigned due; int sel; logic [31:0] val;} rlfs_note_t;
  rlfs_note_t q[$];
  int n_errors = 0;
  int tests_run = 0;
  int nb;
  int ns;
  int unsigned cyc = 0;
  logic [31:0] r = 32'h78ef;
  logic [31:0] seed = 32'h0;
  logic [7:0] kind = 8'h00;
  logic [7:0] kt [4] = '{8'hde, 8'hff, 8'haa, 8'h00};
  logic [19:0] bt [3] = '{20'h80001, 20'h00010, 20'hfffff};
  logic [7:0] pt [5] = '{8'h40, 8'h20, 8'h04, 8'h01, 8'h00};
  logic [2:0] ct [3] = '{3'h6, 3'h0, 3'h3};
  logic mark = 1'b0;
  logic [19:0] bip_bad = 20'h0;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [99:0] lane_map_in = '0;
  logic [19:0] lane_sync_in = '0;
  logic [19:0] lane_demux_in = '0;
  logic align_ok = 1'b1;
  logic pkt_start = 1'b0;
  logic [7:0] pkt_bytes = 8'h00;
  logic test_pattern_on = 1'b0;
  logic ber_excess_in = 1'b0;
  logic partner_fault_in = 1'b0;
  rlfs_pkg::rlfs_bus_t bus = '0;
  rlfs_pkg::rlfs_fcs_t fcs_ends [4];
  rlfs_pkg::rlfs_bip_t bip_in;
  logic [31:0] rdata;
  logic [99:0] lane_index;
  logic [4:0] pcs_lane19_physical_index;
  logic [19:0] lane_sync_vector;
  logic [19:0] lane_marker_found_vector;
  logic [3:0] bad_checksum_count;
  logic [3:0] inverted_checksum_count;
  logic truncated_pulse;
  logic cut_packet;
  logic internal_fault;
  logic received_fault;
  logic [19:0] bip_error;
  logic error_rate_excess_flag;
  logic irq;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  rlfs_top rlfs_top_inst (.*);
  rlfs_partner rlfs_partner_inst (.kind(kind), .mark(mark),
    .bip_bad(bip_bad), .seed(seed), .ends(fcs_ends), .bip(bip_in));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] obs(input int s);
    case (s)
      0: return rdata;
      1: return {28'h0, bad_checksum_count};
      2: return {28'h0, inverted_checksum_count};
      3: return {31'h0, truncated_pulse};
      4: return {12'h0, bip_error};
      5: return {31'h0, irq};
      6: return {27'h0, pcs_lane19_physical_index};
      8: return {31'h0, received_fault};
      9: return {31'h0, error_rate_excess_flag};
      default: return {31'h0, internal_fault};
    endcase
  endfunction
  task automatic note(input int sel, input logic [31:0] val, input int d = 2);
    q.push_back('{cyc + d, sel, val});
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bus_op(input logic [3:0] a, input logic [31:0] d,
    input logic w);
    tick();
    bus <= '{a, d, w, !w};
    if (!w) note(0, d);
    tick();
    bus <= '0;
  endtask
  task automatic end_of_test();
    n_errors += q.size();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(negedge clk_sys)
    while (q.size() > 0 && q[0].due <= cyc) begin
      check(obs(q[0].sel), q[0].val);
      void'(q.pop_front());
    end
  initial begin
    #40000;
    n_errors++;
    end_of_test();
  end
  initial begin
    tick(5);
    srst <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      r = lfsr(r);
      tick();
      lane_map_in <= {r[3:0], {3{r}}};
      lane_sync_in <= r[19:0];
      lane_demux_in <= r[31:12];
      note(6, {27'h0, r[3:0], r[31]});
    end
    $display("lane map test done");
    bus_op(rlfs_pkg::OFS_IRQ_ENABLE, 32'h2, 1'b1);
    foreach (kt[j]) begin
      r = lfsr(r);
      tick();
      seed <= r;
      kind <= kt[j];
      nb = 0;
      ns = 0;
      for (int i = 0; i < 4; i++) begin
        nb += kt[j][2*i+:2] == 2'h2;
        ns += kt[j][2*i+:2] == 2'h3;
      end
      note(1, nb);
      note(2, ns);
    end
    tick(4);
    note(5, 32'h1, 1);
    bus_op(rlfs_pkg::OFS_IRQ_STATUS, 32'h3, 1'b0);
    bus_op(rlfs_pkg::OFS_IRQ_CLEAR, 32'h3f, 1'b1);
    tick(3);
    note(5, 32'h0, 1);
    bus_op(4'hf, 32'h0, 1'b0);
    bus_op(rlfs_pkg::OFS_IRQ_ENABLE, 32'h2, 1'b0);
    $display("checksum and interrupt test done");
    foreach (bt[j]) begin
      tick();
      mark <= j < 2;
      bip_bad <= bt[j];
      note(4, j < 2 ? {12'h0, bt[j]} : 32'h0);
    end
    $display("marker test done");
    bus_op(rlfs_pkg::OFS_MAX_LEN, 32'h64, 1'b1);
    bus_op(rlfs_pkg::OFS_MAX_LEN, 32'h64, 1'b0);
    foreach (pt[j]) begin
      tick();
      pkt_start <= j == 0;
      pkt_bytes <= pt[j];
      note(3, j == 3);
    end
    $display("truncation test done");
    foreach (ct[j]) begin
      tick();
      {test_pattern_on, align_ok, ber_excess_in} <= ct[j];
      partner_fault_in <= j == 1;
      note(7, 32'h1);
      note(8, j == 1);
      note(9, ct[j][0]);
      tick();
      {test_pattern_on, align_ok, ber_excess_in} <= 3'h2;
      note(7, 32'h0);
    end
    tick();
    ber_excess_in <= 1'b1;
    srst <= 1'b1;
    tick(2);
    note(7, 32'h0, 1);
    note(7, 32'h1);
    srst <= 1'b0;
    $display("fault and reset test done");
    tick(5);
    end_of_test();
  end
endmodule
`default_nettype wire
